// file: design/rbr_consts.vh
// Constants of the block-read command unit
`ifndef RBR_CONSTS_VH
`define RBR_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RBR_OFF_CMD       12'h000
`define RBR_OFF_RESULT    12'h004
`define RBR_OFF_PARAM0    12'h008
`define RBR_OFF_PARAM1    12'h00C
`define RBR_OFF_PARAM2    12'h010
`define RBR_OFF_STATUS    12'h014
`define RBR_OFF_MASK      12'h018
`define RBR_OFF_BUSY      12'h01C
`define RBR_OFF_BUF       12'h100

// ----------------------------------------------------------------------
// Command codes and result codes
// ----------------------------------------------------------------------
`define RBR_CMD_NOP       8'h00
`define RBR_CMD_READ      8'h02
`define RBR_CMD_WRITE     8'h03
`define RBR_RES_OK        8'h00
`define RBR_RES_AUTH      8'h01
`define RBR_RES_READ      8'h02
`define RBR_RES_TAG       8'h03
`define RBR_RES_PARAM     8'h04
`define RBR_RES_CMD       8'h05

// ----------------------------------------------------------------------
// Field positions, sizes and reset values
// ----------------------------------------------------------------------
`define RBR_KSEL_ROLE_B   7
`define RBR_KSEL_ARG_KEY  6
`define RBR_KEY_IDX_MAX   6'h27
`define RBR_ST_DONE       0
`define RBR_ST_ERR        1
`define RBR_ST_W          2
`define RBR_BUF_DEPTH     64
`define RBR_BUF_AW        6
`define RBR_BLK_LIMIT     9'h100
`define RBR_SEC_BIG_FIRST 6'h20
`define RBR_RST_WORD      32'h00000000
`define RBR_RST_BYTE      8'h00

`endif

// file: design/rbr_buf_mem.v
// Data buffer: one write port, one registered read port
`timescale 1ns/1ps
`include "rbr_consts.vh"
module rbr_buf_mem (
    input  wire                     ref_clk,
    input  wire                     wr_en,
    input  wire [`RBR_BUF_AW-1:0]   wr_addr,
    input  wire [7:0]               wr_data,
    input  wire [`RBR_BUF_AW-1:0]   rd_addr,
    output wire [7:0]               rd_data
);
    reg [7:0] mem_reg [0:`RBR_BUF_DEPTH-1];
    reg [7:0] rd_data_reg;

    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data_reg <= mem_reg[rd_addr];
    end

    assign rd_data = rd_data_reg;
endmodule // rbr_buf_mem

// file: design/rbr_sector_map.v
// Block number to tag sector number
`timescale 1ns/1ps
`include "rbr_consts.vh"
module rbr_sector_map (
    input  wire [7:0] blk,
    output wire [5:0] sector
);
    // Small sectors of 4 blocks below block 128, large ones of 16 above
    assign sector = blk[7] ? (`RBR_SEC_BIG_FIRST + {3'b000, blk[6:4]}) : blk[7:2];
endmodule // rbr_sector_map

// file: design/rbr_cmd.v
// Block-read command unit with APB registers, data buffer and tag requests
//
// Behaviour
// - Code 0x02 starts a multi-block read, only for the classic sector tag family.
// - Parameters: start block, count, buffer offset, key selector, then six key bytes.
// - Key selector top bit chooses the key role used for authentication.
// - Six-byte key is taken least significant byte first.
// - Sector of the starting block is authenticated before any block is read.
// - Failed authentication writes an error result and ends the command.
// - Starting block is read first, then following blocks while count remains.
// - A block in a new sector triggers authentication of that sector, same key.
// - On success bytes lie contiguously from the offset, result is no-error.
// - A block that cannot be read gives an error result.
// - Code 0x03 is the multi-block write, only for the classic tag family.
// - Selector: low six bits key index 0..39, bit 7 role B, bit 6 argument key.
// - Result register is updated at the end of every executed command, except a write on a classic tag, which only pulses wr_start.
`timescale 1ns/1ps
`include "rbr_consts.vh"
module rbr_cmd (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq,
    output wire        cmd_busy,
    input  wire        tag_classic,
    output wire        auth_req,
    output wire [5:0]  auth_sector,
    output wire        auth_key_b,
    output wire        auth_key_arg,
    output wire [5:0]  auth_key_idx,
    output wire [47:0] auth_key,
    input  wire        auth_done,
    input  wire        auth_ok,
    output wire        blk_rd_req,
    output wire [7:0]  blk_addr,
    input  wire        rd_valid,
    input  wire [7:0]  rd_byte,
    input  wire        rd_done,
    input  wire        rd_err,
    output wire        wr_start
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [6:0] S_IDLE   = 7'b0000001;
    localparam [6:0] S_CHECK  = 7'b0000010;
    localparam [6:0] S_AUTH   = 7'b0000100;
    localparam [6:0] S_AUTH_W = 7'b0001000;
    localparam [6:0] S_RD     = 7'b0010000;
    localparam [6:0] S_RD_W   = 7'b0100000;
    localparam [6:0] S_DONE   = 7'b1000000;

    reg [6:0]               state_reg;
    reg [7:0]               cmd_reg;
    reg [7:0]               result_reg;
    reg [7:0]               res_hold_reg;
    reg [31:0]              param0_reg;
    reg [31:0]              param1_reg;
    reg [15:0]              param2_reg;
    reg [`RBR_ST_W-1:0]     status_reg;
    reg [`RBR_ST_W-1:0]     mask_reg;
    reg                     busy_reg;
    reg                     irq_reg;
    reg [31:0]              prdata_reg;
    reg                     pready_reg;
    reg                     pslverr_reg;
    reg                     auth_req_reg;
    reg [5:0]               auth_sector_reg;
    reg                     auth_key_b_reg;
    reg                     auth_key_arg_reg;
    reg [5:0]               auth_key_idx_reg;
    reg [47:0]              auth_key_reg;
    reg                     blk_rd_req_reg;
    reg [7:0]               blk_reg;
    reg [7:0]               remain_reg;
    reg [`RBR_BUF_AW-1:0]   ptr_reg;
    reg                     wr_start_reg;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire       apb_access = psel & penable;
    wire       apb_end    = apb_access & pready_reg;
    wire       buf_hit    = (paddr[11:8] == `RBR_OFF_BUF >> 8) &&
                            (paddr[7:2] < `RBR_BUF_DEPTH);
    wire       reg_hit    = (paddr == `RBR_OFF_CMD)    || (paddr == `RBR_OFF_RESULT) ||
                            (paddr == `RBR_OFF_PARAM0) || (paddr == `RBR_OFF_PARAM1) ||
                            (paddr == `RBR_OFF_PARAM2) || (paddr == `RBR_OFF_STATUS) ||
                            (paddr == `RBR_OFF_MASK)   || (paddr == `RBR_OFF_BUSY);
    wire       wr_commit  = apb_end & pwrite;
    wire       status_rd  = apb_end & ~pwrite & (paddr == `RBR_OFF_STATUS);
    wire       cmd_start  = (state_reg == S_IDLE) & (cmd_reg != `RBR_CMD_NOP);

    // Parameter list fields, byte 0 in the lowest lane
    wire [7:0] p_start    = param0_reg[7:0];
    wire [7:0] p_count    = param0_reg[15:8];
    wire [7:0] p_offset   = param0_reg[23:16];
    wire [7:0] p_keysel   = param0_reg[31:24];

    // Defensive range checks on the host's request
    wire [12:0] end_byte  = {5'b00000, p_offset} + {1'b0, p_count, 4'h0};
    wire [8:0]  end_blk   = {1'b0, p_start} + {1'b0, p_count};
    wire        bad_param = (p_count == 8'h00) ||
                            (end_byte > `RBR_BUF_DEPTH) ||
                            (end_blk > `RBR_BLK_LIMIT) ||
                            (~p_keysel[`RBR_KSEL_ARG_KEY] &&
                             (p_keysel[5:0] > `RBR_KEY_IDX_MAX));

    // ------------------------------------------------------------------
    // Sector tracking
    // ------------------------------------------------------------------
    wire [5:0] sec_cur;
    wire [5:0] sec_next;
    wire [7:0] blk_inc = blk_reg + 8'h01;

    rbr_sector_map u_sec_cur (
        .blk    (blk_reg),
        .sector (sec_cur)
    );

    rbr_sector_map u_sec_next (
        .blk    (blk_inc),
        .sector (sec_next)
    );

    // ------------------------------------------------------------------
    // Data buffer
    // ------------------------------------------------------------------
    wire                   eng_we  = (state_reg == S_RD_W) & rd_valid;
    wire                   host_we = wr_commit & buf_hit & ~busy_reg;
    wire                   mem_we  = eng_we | host_we;
    wire [`RBR_BUF_AW-1:0] mem_wa  = eng_we ? ptr_reg : paddr[`RBR_BUF_AW+1:2];
    wire [7:0]             mem_wd  = eng_we ? rd_byte : pwdata[7:0];
    wire [7:0]             mem_rd;

    rbr_buf_mem u_buf (
        .ref_clk (ref_clk),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (paddr[`RBR_BUF_AW+1:2]),
        .rd_data (mem_rd)
    );

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    reg [31:0] rdata_mux;

    always @* begin
        rdata_mux = `RBR_RST_WORD;
        if (buf_hit) begin
            rdata_mux = {24'h000000, mem_rd};
        end else begin
            case (paddr)
                `RBR_OFF_CMD:    rdata_mux = {24'h000000, cmd_reg};
                `RBR_OFF_RESULT: rdata_mux = {24'h000000, result_reg};
                `RBR_OFF_PARAM0: rdata_mux = param0_reg;
                `RBR_OFF_PARAM1: rdata_mux = param1_reg;
                `RBR_OFF_PARAM2: rdata_mux = {16'h0000, param2_reg};
                `RBR_OFF_STATUS: rdata_mux = {30'h00000000, status_reg};
                `RBR_OFF_MASK:   rdata_mux = {30'h00000000, mask_reg};
                `RBR_OFF_BUSY:   rdata_mux = {31'h00000000, busy_reg};
                default:         rdata_mux = `RBR_RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, so buffer data come from a register
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= `RBR_RST_WORD;
        end else begin
            pready_reg  <= apb_access & ~pready_reg;
            pslverr_reg <= apb_access & ~pready_reg & ~(reg_hit | buf_hit);
            if (apb_access & ~pready_reg & ~pwrite) begin
                prdata_reg <= rdata_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status: set wins over read-clear
    // ------------------------------------------------------------------
    wire                 done_now = (state_reg == S_DONE);
    wire [`RBR_ST_W-1:0] st_set   = {done_now & (res_hold_reg != `RBR_RES_OK), done_now};
    wire [`RBR_ST_W-1:0] st_next  = (status_rd ? {`RBR_ST_W{1'b0}} : status_reg) | st_set;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            status_reg <= {`RBR_ST_W{1'b0}};
            mask_reg   <= {`RBR_ST_W{1'b0}};
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= st_next;
            if (wr_commit && (paddr == `RBR_OFF_MASK)) begin
                mask_reg <= pwdata[`RBR_ST_W-1:0];
            end
            irq_reg <= |(st_next & mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // Host-written parameters, locked while a command runs
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            param0_reg <= `RBR_RST_WORD;
            param1_reg <= `RBR_RST_WORD;
            param2_reg <= 16'h0000;
        end else if (wr_commit & ~busy_reg) begin
            if (paddr == `RBR_OFF_PARAM0) begin
                param0_reg <= pwdata;
            end
            if (paddr == `RBR_OFF_PARAM1) begin
                param1_reg <= pwdata;
            end
            if (paddr == `RBR_OFF_PARAM2) begin
                param2_reg <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg        <= S_IDLE;
            cmd_reg          <= `RBR_CMD_NOP;
            result_reg       <= `RBR_RES_OK;
            res_hold_reg     <= `RBR_RES_OK;
            busy_reg         <= 1'b0;
            auth_req_reg     <= 1'b0;
            auth_sector_reg  <= 6'h00;
            auth_key_b_reg   <= 1'b0;
            auth_key_arg_reg <= 1'b0;
            auth_key_idx_reg <= 6'h00;
            auth_key_reg     <= 48'h000000000000;
            blk_rd_req_reg   <= 1'b0;
            blk_reg          <= `RBR_RST_BYTE;
            remain_reg       <= `RBR_RST_BYTE;
            ptr_reg          <= {`RBR_BUF_AW{1'b0}};
            wr_start_reg     <= 1'b0;
        end else begin
            auth_req_reg   <= 1'b0;
            blk_rd_req_reg <= 1'b0;
            wr_start_reg   <= 1'b0;
            if (wr_commit && (paddr == `RBR_OFF_CMD) && ~busy_reg) begin
                cmd_reg <= pwdata[7:0];
            end
            case (state_reg)
                S_IDLE: begin
                    if (cmd_start) begin
                        busy_reg  <= 1'b1;
                        state_reg <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (cmd_reg == `RBR_CMD_READ) begin
                        if (~tag_classic) begin
                            res_hold_reg <= `RBR_RES_TAG;
                            state_reg    <= S_DONE;
                        end else if (bad_param) begin
                            res_hold_reg <= `RBR_RES_PARAM;
                            state_reg    <= S_DONE;
                        end else begin
                            blk_reg          <= p_start;
                            remain_reg       <= p_count;
                            ptr_reg          <= p_offset[`RBR_BUF_AW-1:0];
                            auth_key_b_reg   <= p_keysel[`RBR_KSEL_ROLE_B];
                            auth_key_arg_reg <= p_keysel[`RBR_KSEL_ARG_KEY];
                            auth_key_idx_reg <= p_keysel[5:0];
                            auth_key_reg     <= {param2_reg, param1_reg};
                            state_reg        <= S_AUTH;
                        end
                    end else if (cmd_reg == `RBR_CMD_WRITE) begin
                        if (~tag_classic) begin
                            res_hold_reg <= `RBR_RES_TAG;
                            state_reg    <= S_DONE;
                        end else begin
                            wr_start_reg <= 1'b1;
                            cmd_reg      <= `RBR_CMD_NOP;
                            busy_reg     <= 1'b0;
                            state_reg    <= S_IDLE;
                        end
                    end else begin
                        res_hold_reg <= `RBR_RES_CMD;
                        state_reg    <= S_DONE;
                    end
                end
                S_AUTH: begin
                    auth_req_reg    <= 1'b1;
                    auth_sector_reg <= sec_cur;
                    state_reg       <= S_AUTH_W;
                end
                S_AUTH_W: begin
                    if (auth_done) begin
                        if (auth_ok) begin
                            state_reg <= S_RD;
                        end else begin
                            res_hold_reg <= `RBR_RES_AUTH;
                            state_reg    <= S_DONE;
                        end
                    end
                end
                S_RD: begin
                    blk_rd_req_reg <= 1'b1;
                    state_reg      <= S_RD_W;
                end
                S_RD_W: begin
                    if (rd_valid) begin
                        ptr_reg <= ptr_reg + 1'b1;
                    end
                    if (rd_done) begin
                        if (rd_err) begin
                            res_hold_reg <= `RBR_RES_READ;
                            state_reg    <= S_DONE;
                        end else if (remain_reg == 8'h01) begin
                            res_hold_reg <= `RBR_RES_OK;
                            state_reg    <= S_DONE;
                        end else begin
                            remain_reg <= remain_reg - 8'h01;
                            blk_reg    <= blk_inc;
                            state_reg  <= (sec_next != sec_cur) ? S_AUTH : S_RD;
                        end
                    end
                end
                S_DONE: begin
                    result_reg <= res_hold_reg;
                    cmd_reg    <= `RBR_CMD_NOP;
                    busy_reg   <= 1'b0;
                    state_reg  <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign irq          = irq_reg;
    assign cmd_busy     = busy_reg;
    assign auth_req     = auth_req_reg;
    assign auth_sector  = auth_sector_reg;
    assign auth_key_b   = auth_key_b_reg;
    assign auth_key_arg = auth_key_arg_reg;
    assign auth_key_idx = auth_key_idx_reg;
    assign auth_key     = auth_key_reg;
    assign blk_rd_req   = blk_rd_req_reg;
    assign blk_addr     = blk_reg;
    assign wr_start     = wr_start_reg;
endmodule // rbr_cmd

// file: sim/rbr_cmd_props.sv
// Assertions on the ports of the block-read command unit
`timescale 1ns/1ps
module rbr_cmd_props (
    input logic       ref_clk,
    input logic       sys_rst,
    input logic       psel,
    input logic       penable,
    input logic       pready,
    input logic       pslverr,
    input logic       cmd_busy,
    input logic       auth_req,
    input logic [5:0] auth_sector,
    input logic       auth_done,
    input logic       auth_ok,
    input logic       blk_rd_req,
    input logic [7:0] blk_addr,
    input logic       rd_done,
    input logic       wr_start
);
    logic authed;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ----
    // Sector granted in the running command
    // ----
    always @(posedge ref_clk) begin
        if (sys_rst || !cmd_busy)
            authed <= 1'b0;
        else if (auth_done)
            authed <= auth_ok;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    sequence s_next;
        blk_rd_req || auth_req || !cmd_busy;
    endsequence
    a_ready_wait: assert property (s_setup |=> s_answer)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_auth_first: assert property (blk_rd_req |-> authed)
        else $error("block read without granted sector");
    a_fail_ends: assert property (auth_done && !auth_ok && cmd_busy |-> ##[1:6] !cmd_busy)
        else $error("command runs on after refused authentication");
    a_read_follows: assert property (auth_done && auth_ok && cmd_busy |-> ##[1:3] blk_rd_req)
        else $error("no block read after authentication");
    a_sector_match: assert property (blk_rd_req |->
        auth_sector == (blk_addr[7] ? {3'b100, blk_addr[6:4]} : blk_addr[7:2]))
        else $error("block read outside the granted sector");
    a_block_next: assert property (rd_done && cmd_busy |-> ##[1:4] s_next)
        else $error("no step after block end");
    a_idle_quiet: assert property (!cmd_busy |-> !auth_req && !blk_rd_req)
        else $error("tag request while idle");
    a_write_hands: assert property (wr_start |=> !wr_start ##[0:1] !cmd_busy)
        else $error("write hand-over not a pulse");
    a_auth_pulse: assert property (auth_req |=> !auth_req) else $error("auth_req held");
endmodule // rbr_cmd_props

// file: sim/rbr_tag_model.sv
// Tag-side model answering authentication and block reads
`timescale 1ns/1ps
module rbr_tag_model (
    input  wire       ref_clk,
    input  wire       auth_req,
    input  wire       blk_rd_req,
    input  wire [7:0] blk_addr,
    input  wire       auth_fail,
    input  wire       rd_fail,
    input  wire [3:0] lag,
    output reg        auth_done,
    output reg        auth_ok,
    output reg        rd_valid,
    output reg  [7:0] rd_byte,
    output reg        rd_done,
    output reg        rd_err
);
    integer   n;
    reg [7:0] b;
    initial begin
        {auth_done, auth_ok, rd_valid, rd_done, rd_err} = 5'h00;
        rd_byte = 8'h00;
    end
    always @(posedge ref_clk) begin
        if (auth_req) begin
            repeat (lag) @(posedge ref_clk);
            auth_done <= 1'b1;
            auth_ok   <= !auth_fail;
            @(posedge ref_clk);
            auth_done <= 1'b0;
            auth_ok   <= auth_fail;
        end else if (blk_rd_req) begin
            b = blk_addr;
            for (n = 0; n < 16; n = n + 1) begin
                if (lag != 4'h0) begin
                    rd_valid <= 1'b0;
                    rd_byte  <= ~{b[3:0], n[3:0]};
                    repeat (lag) @(posedge ref_clk);
                end
                rd_valid <= 1'b1;
                rd_byte  <= {b[3:0], n[3:0]};
                @(posedge ref_clk);
            end
            rd_valid <= 1'b0;
            rd_byte  <= ~rd_byte;
            rd_done <= 1'b1;
            rd_err  <= rd_fail;
            @(posedge ref_clk);
            rd_done <= 1'b0;
            rd_err  <= !rd_fail;
        end
    end
endmodule // rbr_tag_model

// file: sim/rbr_cmd_tb_top.sv
// Testbench of the block-read command unit
`timescale 1ns/1ps
`include "rbr_consts.vh"
module rbr_cmd_tb_top;
    logic        ref_clk, sys_rst, psel, penable, pwrite, tag_classic, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, irq, cmd_busy, auth_req, auth_key_b, auth_key_arg;
    logic [5:0]  auth_sector, auth_key_idx, idx_seen;
    logic [47:0] auth_key, key_seen;
    logic        auth_done, auth_ok, blk_rd_req, rd_valid, rd_done, rd_err, wr_start;
    logic [7:0]  blk_addr, rd_byte;
    logic        auth_fail, rd_fail, role_seen, arg_seen;
    logic [3:0]  lag;
    integer      bad_count, num_checks, n_auth, n_rd, n_wr, cyc, i;
    logic [31:0] tp [0:5] = '{32'h00000005, 32'h00310105, 32'h28000105, 32'h00000105,
                              32'h00000105, 32'h00000105};
    logic [7:0]  tc [0:5] = '{8'h02, 8'h02, 8'h02, 8'h07, 8'h02, 8'h03};
    logic [7:0]  te [0:5] = '{8'h04, 8'h04, 8'h04, 8'h05, 8'h03, 8'h03};

    rbr_cmd i_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .cmd_busy, .tag_classic, .auth_req, .auth_sector,
        .auth_key_b, .auth_key_arg, .auth_key_idx, .auth_key, .auth_done, .auth_ok,
        .blk_rd_req, .blk_addr, .rd_valid, .rd_byte, .rd_done, .rd_err, .wr_start);
    rbr_tag_model i_tag (.ref_clk, .auth_req, .blk_rd_req, .blk_addr, .auth_fail, .rd_fail,
        .lag, .auth_done, .auth_ok, .rd_valid, .rd_byte, .rd_done, .rd_err);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ----
    // Monitor of tag requests
    // ----
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (auth_req) begin
            n_auth    = n_auth + 1;
            key_seen  = auth_key;
            role_seen = auth_key_b;
            arg_seen  = auth_key_arg;
            idx_seen  = auth_key_idx;
        end
        if (blk_rd_req) n_rd = n_rd + 1;
        if (wr_start) n_wr = n_wr + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            test_done;
        end
    end

    task check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task run(input logic [31:0] p0, input logic [7:0] code);
        n_auth = 0; n_rd = 0; n_wr = 0;
        apb(1'b1, `RBR_OFF_PARAM0, p0);
        apb(1'b1, `RBR_OFF_CMD, {24'h000000, code});
        repeat (3) @(posedge ref_clk);
        while (cmd_busy !== 1'b0) @(posedge ref_clk);
        apb(1'b0, `RBR_OFF_RESULT, 32'h0);
    endtask
    task test_done;
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {sys_rst, tag_classic} = 2'b11;
        {psel, penable, pwrite, auth_fail, rd_fail} = 5'h00;
        paddr = 12'h000; pwdata = 32'h0; lag = 4'h0;
        {bad_count, num_checks, n_auth, n_rd, n_wr, cyc} = '0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) if (i < 2 || i > 4) begin
            apb(1'b0, 4 * i, 32'h0);
            check(q, 32'h0);
        end
        apb(1'b0, 12'h040, 32'h0);
        check({err, q}, {1'b1, 32'h0});
        for (i = 0; i < 64; i++) apb(1'b1, `RBR_OFF_BUF + 4 * i, 32'hA5);
        apb(1'b1, `RBR_OFF_MASK, 32'h3);
        // ----
        // Three blocks across a sector edge, stored key, role B
        // ----
        run(32'h85080302, 8'h02);
        check(q, 32'h0);
        check({n_auth, n_rd}, {32'd2, 32'd3});
        check({role_seen, arg_seen, idx_seen}, {2'b10, 6'h05});
        check(irq, 1'b1);
        for (i = 0; i < 64; i++) begin
            apb(1'b0, `RBR_OFF_BUF + 4 * i, 32'h0);
            check(q, (i < 8 || i > 55) ? 32'hA5 : i + 24);
        end
        apb(1'b0, `RBR_OFF_STATUS, 32'h0);
        check(q, 32'h1);
        apb(1'b0, `RBR_OFF_STATUS, 32'h0);
        check({irq, q}, {1'b0, 32'h0});
        // ----
        // Argument key refused, then failing block
        // ----
        apb(1'b1, `RBR_OFF_PARAM1, 32'h04030201);
        apb(1'b1, `RBR_OFF_PARAM2, 32'h00000605);
        {auth_fail, lag} = {1'b1, 4'h3};
        run(32'h40000110, 8'h02);
        check(q, 32'h1);
        check({key_seen, role_seen, arg_seen}, {48'h060504030201, 2'b01});
        check(n_rd, 0);
        {auth_fail, rd_fail} = 2'b01;
        run(32'h00000181, 8'h02);
        check(q, 32'h2);
        rd_fail = 1'b0;
        for (i = 0; i < 6; i++) begin
            tag_classic <= (i != 4) && !(i == 5 && n_wr == 0 && tc[4] != 8'h02);
            run(tp[i], tc[i]);
            check(q, te[i]);
        end
        tag_classic <= 1'b1;
        run(32'h00000105, 8'h03);
        check({n_wr, q}, {32'd1, 32'h3});
        test_done;
    end
endmodule // rbr_cmd_tb_top

bind rbr_cmd rbr_cmd_props i_props (.ref_clk, .sys_rst, .psel, .penable, .pready, .pslverr,
    .cmd_busy, .auth_req, .auth_sector, .auth_done, .auth_ok, .blk_rd_req, .blk_addr,
    .rd_done, .wr_start);
